// [bench/serial_port_config_regs_tb_top.sv]
// testbench of the serial port setup registers
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs_tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic i2c_mode = 1'b0;
  logic eeprom_pin = 1'b1;
  logic [7:0] buf_rdata = 8'hC3;
  logic [7:0] act_rdata = 8'h3C;
  logic sclk_pin, csb_pin, sdio_in, sdio_out, sdio_oe_b, sdo_out, sdo_oe_b;
  logic reg_we, load_eeprom, load_default, split_pin_mode, lsb_first;
  logic readback_active, ord;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [15:0] q;
  logic [17:0] wlog[$];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int ne = 0;
  int nd = 0;
  always #12.5 mclk = ~mclk;
  spc_port i_dut (.*);
  spc_host i_host (.*);
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    ne <= ne + load_eeprom;
    nd <= nd + load_default;
    if (reg_we)
      wlog.push_back({reg_addr, reg_wdata});
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic cmp(input logic [17:0] g, input logic [17:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d, input int n);
    i_host.xfer(1'b0, a, n, ord, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    i_host.xfer(1'b1, a, 1, ord, 16'h0000, q);
    cmp({10'h000, q[7:0]}, {10'h000, e});
  endtask
  initial begin
    ord = 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(10'h000, 8'h00);
    wr(10'h003, 16'h00FF, 1);
    rd(10'h003, 8'h5A);
    wr(10'h004, 16'h00FF, 1);
    rd(10'h004, 8'h01);
    cmp({17'h0, readback_active}, 18'h1);
    rd(10'h010, 8'h3C);
    wr(10'h004, 16'h0000, 1);
    rd(10'h010, 8'hC3);
    $display("test regs done");
    wr(10'h000, 16'h0081, 1);
    rd(10'h003, 8'h5A);
    wr(10'h000, 16'h0000, 1);
    wr(10'h010, 16'hA55A, 2);
    cmp(wlog.pop_front(), {10'h010, 8'hA5});
    cmp(wlog.pop_front(), {10'h00F, 8'h5A});
    wr(10'h000, 16'h0042, 1);
    ord = 1'b1;
    wr(10'h010, 16'hA55A, 2);
    cmp(wlog.pop_front(), {10'h010, 8'hA5});
    cmp(wlog.pop_front(), {10'h011, 8'h5A});
    wr(10'h000, 16'h0000, 1);
    ord = 1'b0;
    $display("test order done");
    i2c_mode <= 1'b1;
    wr(10'h000, 16'h0042, 1);
    i2c_mode <= 1'b0;
    repeat (8) @(posedge mclk);
    cmp({17'h0, lsb_first}, 18'h0);
    wr(10'h000, 16'h0024, 1);
    repeat (20) @(posedge mclk);
    cmp(18'(ne), 18'h1);
    eeprom_pin <= 1'b0;
    wr(10'h004, 16'h0001, 1);
    wr(10'h000, 16'h0024, 1);
    repeat (20) @(posedge mclk);
    cmp(18'(nd), 18'h1);
    cmp({17'h0, readback_active}, 18'h0);
    $display("test reset done");
    end_sim();
  end
endmodule // serial_port_config_regs_tb_top
`default_nettype wire

// [bench/spc_chk_checker.sv]
// assertions on the serial port setup ports
`timescale 1ns/1ps
`default_nettype none
module spc_chk (
  input wire logic mclk, rst_b, csb_pin, i2c_mode, eeprom_pin,
  input wire logic sdio_oe_b, sdo_oe_b, reg_we, load_eeprom, load_default,
  input wire logic split_pin_mode, lsb_first,
  input wire logic [9:0] reg_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_idle; csb_pin [*8]; endsequence
  sequence s_one; !split_pin_mode [*4]; endsequence
  sequence s_two; split_pin_mode [*4]; endsequence
  sequence s_ld; load_eeprom || load_default; endsequence
  property p_one; s_one |-> sdo_oe_b; endproperty
  a_one: assert property (p_one) else $error("sdo driven");
  property p_two; s_two |-> sdio_oe_b; endproperty
  a_two: assert property (p_two) else $error("sdio driven");
  property p_excl; !sdio_oe_b |-> sdo_oe_b; endproperty
  a_excl: assert property (p_excl) else $error("both driven");
  property p_idle; s_idle |-> sdio_oe_b && sdo_oe_b; endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_i2c; i2c_mode [*4] |-> !lsb_first; endproperty
  a_i2c: assert property (p_i2c) else $error("lsb in i2c");
  // only the three local offsets stay off the outer write port
  property p_ro;
    reg_we |-> reg_addr != 10'h000 && reg_addr != 10'h003 &&
      reg_addr != 10'h004;
  endproperty
  a_ro: assert property (p_ro) else $error("local write out");
  property p_src; s_ld |-> load_eeprom == $past(eeprom_pin, 3); endproperty
  a_src: assert property (p_src) else $error("wrong source");
  property p_clr; s_ld |=> !load_eeprom && !load_default; endproperty
  a_clr: assert property (p_clr) else $error("no self clear");
endmodule // spc_chk
bind spc_port spc_chk i_chk (.*);
`default_nettype wire

// [bench/spc_host.sv]
// spi host model that drives the serial port pins
`timescale 1ns/1ps
`default_nettype none
module spc_host (
  // clock and device outputs
  input wire logic mclk, sdio_out, sdio_oe_b, sdo_out, sdo_oe_b,
  // spi pins
  output logic sclk_pin, csb_pin, sdio_in
);
  logic drv = 1'b0;
  // shared line level; host toggles it while released
  assign sdio_in = sdio_oe_b ? drv : sdio_out;
  initial begin
    sclk_pin = 1'b0;
    csb_pin = 1'b1;
  end
  // clock stands low between frames, bits change with the falling edge
  task automatic bitx(input logic b, output logic s);
    drv <= b;
    sclk_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    sclk_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    s = !sdo_oe_b ? sdo_out : !sdio_oe_b ? sdio_out : 1'bx;
  endtask
  task automatic xfer(input logic rd, input logic [9:0] a, input int n,
    input logic lsb, input logic [15:0] wd, output logic [15:0] q);
    logic s;
    int k;
    logic [15:0] ins;
    q = 16'h0000;
    ins = {rd, 5'h00, a};
    csb_pin <= 1'b0;
    for (int i = 15; i >= 0; i--)
      bitx(ins[i], s);
    for (int i = 0; i < 8 * n; i++) begin
      k = 8 * (n - 1 - i / 8) + (lsb ? i % 8 : 7 - i % 8);
      bitx(rd ? !drv : wd[k], s);
      q[k] = s;
    end
    sclk_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    csb_pin <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule // spc_host
`default_nettype wire

// [rtl/spc_port.v]
// serial port setup registers with spi shift engine
`timescale 1ns/1ps
`default_nettype none
`include "spc_regs.vh"
// How it works
// - bit 7 clear: one shared data pin
// - bit 7 set: reads on separate out pin
// - bit 6 clear: msb first, address steps down
// - bit 6 set: lsb first, address steps up
// - i2c mode ignores bit 6
// - soft reset self-clears, eeprom load if pin high
// - pin low: soft reset restores defaults
// - read-only variant code at 0x003
// - readback_select bit 0 picks buffer or active
module spc_port (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // spi pins
  input wire sclk_pin,
  input wire csb_pin,
  input wire sdio_in,
  output reg sdio_out,
  output reg sdio_oe_b,
  output reg sdo_out,
  output reg sdo_oe_b,
  // mode and eeprom strap pins
  input wire i2c_mode,
  input wire eeprom_pin,
  // register read data from the rest of the chip
  input wire [7:0] buf_rdata,
  input wire [7:0] act_rdata,
  // external register write port
  output reg [`SPC_ADDR_W-1:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_we,
  // soft reset requests
  output reg load_eeprom,
  output reg load_default,
  // setup state
  output wire split_pin_mode,
  output wire lsb_first,
  output wire readback_active
);
  // ----------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------
  wire [4:0] pins_s;
  spc_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({sclk_pin, csb_pin, sdio_in, i2c_mode, eeprom_pin}),
    .q(pins_s)
  );
  wire sclk_s = pins_s[4];
  wire csb_s = pins_s[3];
  wire din_s = pins_s[2];
  wire i2c_s = pins_s[1];
  wire eep_s = pins_s[0];
  reg sclk_d_r;
  wire rise = sclk_s & ~sclk_d_r;
  wire fall = ~sclk_s & sclk_d_r;

  // ----------------------------------------------------
  // registers
  // ----------------------------------------------------
  reg split_r, lsbf_r, rbsel_r;
  reg [2:0] srst_cnt_r;
  // reset images of the setup fields
  wire [7:0] setup_rst = `SPC_SETUP_RST;
  wire [7:0] rbsel_rst = `SPC_RBSEL_RST;
  assign split_pin_mode = split_r;
  assign lsb_first = lsbf_r & ~i2c_s;
  assign readback_active = rbsel_r;

  // state passed in so the read mux follows every change
  function [7:0] local_read;
    input [`SPC_ADDR_W-1:0] a;
    input i2c;
    input split;
    input lsbf;
    input rbsel;
    begin
      case (a)
        `SPC_OFF_SETUP: local_read = i2c ?
          8'h00 : {split, lsbf, 6'h00};
        `SPC_OFF_VARIANT: local_read = `SPC_VARIANT_VAL;
        `SPC_OFF_RBSEL: local_read = {7'h00, rbsel};
        default: local_read = 8'h00;
      endcase
    end
  endfunction

  function is_local;
    input [`SPC_ADDR_W-1:0] a;
    begin
      is_local = (a == `SPC_OFF_SETUP) || (a == `SPC_OFF_VARIANT) ||
                 (a == `SPC_OFF_RBSEL);
    end
  endfunction

  // ----------------------------------------------------
  // spi shift engine
  // ----------------------------------------------------
  localparam ST_CMD = 1'b0;
  localparam ST_DATA = 1'b1;
  reg st_r;
  reg [15:0] cmd_r;
  reg [4:0] cnt_r;
  reg rd_r;
  reg [`SPC_ADDR_W-1:0] addr_r;
  reg [7:0] sh_r;
  reg [7:0] rdsh_r;
  wire [7:0] rd_src = is_local(addr_r) ?
    local_read(addr_r, i2c_s, split_r, lsbf_r, rbsel_r) :
    (rbsel_r ? act_rdata : buf_rdata);
  // the received byte as assembled in either bit order
  wire [7:0] byte_in = lsb_first ? {din_s, sh_r[7:1]}
                                 : {sh_r[6:0], din_s};
  wire [`SPC_ADDR_W-1:0] addr_step = lsb_first ?
    addr_r + 1'b1 : addr_r - 1'b1;
  // instruction always msb first so setup bit flips stay safe
  wire [15:0] cmd_in = {cmd_r[14:0], din_s};

  always @(posedge mclk) begin
    if (!rst_b) begin
      sclk_d_r <= 1'b0;
      st_r <= ST_CMD;
      cmd_r <= 16'h0000;
      cnt_r <= 5'd0;
      rd_r <= 1'b0;
      addr_r <= {`SPC_ADDR_W{1'b0}};
      sh_r <= 8'h00;
      rdsh_r <= 8'h00;
      split_r <= setup_rst[`SPC_BIT_SPLIT];
      lsbf_r <= setup_rst[`SPC_BIT_LSBF];
      rbsel_r <= rbsel_rst[`SPC_BIT_RBSEL];
      srst_cnt_r <= 3'd0;
      reg_addr <= {`SPC_ADDR_W{1'b0}};
      reg_wdata <= 8'h00;
      reg_we <= 1'b0;
      load_eeprom <= 1'b0;
      load_default <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      reg_we <= 1'b0;
      load_eeprom <= 1'b0;
      load_default <= 1'b0;
      if (srst_cnt_r != 3'd0) begin
        srst_cnt_r <= srst_cnt_r - 3'd1;
        if (srst_cnt_r == 3'd1) begin
          // defaults restored on both paths; eeprom then overwrites
          split_r <= setup_rst[`SPC_BIT_SPLIT];
          lsbf_r <= setup_rst[`SPC_BIT_LSBF];
          rbsel_r <= rbsel_rst[`SPC_BIT_RBSEL];
          load_eeprom <= eep_s;
          load_default <= ~eep_s;
        end
      end
      if (csb_s) begin
        st_r <= ST_CMD;
        cnt_r <= 5'd0;
      end else if (rise) begin
        if (st_r == ST_CMD) begin
          cmd_r <= cmd_in;
          cnt_r <= cnt_r + 5'd1;
          if (cnt_r == 5'd15) begin
            st_r <= ST_DATA;
            cnt_r <= 5'd0;
            rd_r <= cmd_in[15];
            addr_r <= cmd_in[`SPC_ADDR_W-1:0];
          end
        end else begin
          sh_r <= byte_in;
          cnt_r <= cnt_r + 5'd1;
          if (cnt_r == 5'd7) begin
            cnt_r <= 5'd0;
            addr_r <= addr_step;
            if (!rd_r) begin
              reg_addr <= addr_r;
              reg_wdata <= byte_in;
              reg_we <= ~is_local(addr_r);
              case (addr_r)
                `SPC_OFF_SETUP: begin
                  split_r <= byte_in[`SPC_BIT_SPLIT];
                  if (!i2c_s)
                    lsbf_r <= byte_in[`SPC_BIT_LSBF];
                  if (byte_in[`SPC_BIT_SRST])
                    srst_cnt_r <= `SPC_SRST_CYC;
                end
                `SPC_OFF_RBSEL: rbsel_r <= byte_in[`SPC_BIT_RBSEL];
                default: ;
              endcase
            end
          end
        end
      end else if (fall && st_r == ST_DATA && rd_r) begin
        // load next byte at its first falling edge
        if (cnt_r == 5'd0)
          rdsh_r <= rd_src;
        else
          rdsh_r <= lsb_first ? {1'b0, rdsh_r[7:1]} : {rdsh_r[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------
  // output pins
  // ----------------------------------------------------
  wire rd_active = ~csb_s & (st_r == ST_DATA) & rd_r;
  wire rd_bit = lsb_first ? rdsh_r[0] : rdsh_r[7];
  always @(posedge mclk) begin
    if (!rst_b) begin
      sdio_out <= 1'b0;
      sdio_oe_b <= 1'b1;
      sdo_out <= 1'b0;
      sdo_oe_b <= 1'b1;
    end else begin
      sdio_out <= rd_bit;
      sdo_out <= rd_bit;
      sdio_oe_b <= ~(rd_active & ~split_r);
      sdo_oe_b <= ~(rd_active & split_r);
    end
  end
endmodule // spc_port
`default_nettype wire

// [rtl/spc_regs.vh]
// register offsets, field positions and reset values of the serial port setup
`ifndef SPC_REGS_VH
`define SPC_REGS_VH
`define SPC_ADDR_W 10
`define SPC_OFF_SETUP 10'h000
`define SPC_OFF_VARIANT 10'h003
`define SPC_OFF_RBSEL 10'h004
`define SPC_BIT_SPLIT 7
`define SPC_BIT_LSBF 6
`define SPC_BIT_SRST 5
`define SPC_BIT_RBSEL 0
`define SPC_SETUP_RST 8'h00
`define SPC_RBSEL_RST 8'h00
// arbitrary neutral value, not a real part code
`define SPC_VARIANT_VAL 8'h5A
`define SPC_SRST_CYC 3'h4
`endif

// [rtl/spc_sync.v]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // pins
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_r;
  always @(posedge mclk) begin
    if (!rst_b) begin
      s1_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule // spc_sync
`default_nettype wire
